/* File: bench/sxe_exec_unit_tb_top.sv */
// Self-checking testbench of the subtract, swap and exclusive-OR execution unit
`timescale 1ns/1ps
`default_nettype none
`include "sxe_defs.svh"
module sxe_exec_unit_tb_top;
  logic clk_in; // Core clock
  logic rstn_in; // Reset, active low
  logic cyc; // Bus cycle
  logic stb; // Bus strobe
  logic we; // Write enable
  logic [7:0] adr; // Byte address
  logic [3:0] sel; // Byte lanes, all used
  logic [31:0] wdat; // Write data
  logic [31:0] rdat; // Data taken at the acknowledge edge
  wire logic [31:0] dat_o; // Read data from the unit
  wire logic ack_o; // Acknowledge from the unit
  int fail_count = 0; // Mismatches
  int tests_run = 0; // Comparisons made
  logic [7:0] lk [4] = '{8'h02, 8'h02, 8'h02, 8'h10}; // Literal operands
  logic [7:0] lw [4] = '{8'h01, 8'h02, 8'h03, 8'h01}; // Accumulator before
  logic [7:0] lr [4] = '{8'h01, 8'h00, 8'hff, 8'h0f}; // Expected difference
  logic [2:0] lf [4] = '{3'b011, 3'b111, 3'b000, 3'b001}; // Expected zero, digit, carry

  sxe_exec_unit u_dut (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .wb_cyc_in(cyc),
    .wb_stb_in(stb),
    .wb_we_in(we),
    .wb_adr_in(adr),
    .wb_sel_in(sel),
    .wb_dat_in(wdat),
    .wb_dat_out(dat_o),
    .wb_ack_out(ack_o)
  );

  // Free-running 50 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Prints the verdict and ends the run
  task conclude;
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  // Compares a seen value with the expected one
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One classic Wishbone cycle, held until acknowledge is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      conclude();
    end
  endtask : bus

  // Reads a register and compares it
  task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h0);
    check(name, rdat, exp);
  endtask : rd

  // Polls the busy bit under a bound
  task wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, `SXE_ADR_STAT, 32'h0);
      n++;
    end while (rdat[`SXE_STAT_BUSY] !== 1'b0 && n < 10);
    if (n >= 10) begin
      fail_count++;
      conclude();
    end
  endtask : wait_idle

  // Starts an instruction and waits for it to finish
  task exec(input logic [13:0] ir);
    bus(1'b1, `SXE_ADR_INSTR, {18'h0, ir});
    wait_idle();
  endtask : exec

  // Loads one file register through the pointer
  task setf(input logic [6:0] f, input logic [7:0] v);
    bus(1'b1, `SXE_ADR_FADR, {25'h0, f});
    bus(1'b1, `SXE_ADR_FDAT, {24'h0, v});
  endtask : setf

  // Main sequence
  initial begin
    rstn_in = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0;
    rdat = 32'h0;
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(`SXE_ADR_DIR, 32'h00ffffff, "dir reset");
    rd(8'h1c, 32'h0, "unmapped");
    // Literal subtract: positive, zero, negative, low-nibble borrow
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `SXE_ADR_ACCUM, {24'h0, lw[i]});
      exec({5'h1e, i[0], lk[i]});
      rd(`SXE_ADR_ACCUM, {24'h0, lr[i]}, "lsub result");
      rd(`SXE_ADR_FLAGS, {29'h0, lf[i]}, "lsub flags");
    end
    // Register subtract into the file, then into the accumulator
    setf(7'd3, 8'h03);
    bus(1'b1, `SXE_ADR_ACCUM, 32'h02);
    exec({6'h02, 1'b1, 7'd3});
    bus(1'b1, `SXE_ADR_FADR, 32'h03);
    rd(`SXE_ADR_FDAT, 32'h01, "rsub file");
    rd(`SXE_ADR_ACCUM, 32'h02, "rsub accum kept");
    rd(`SXE_ADR_FLAGS, 32'h03, "rsub flags");
    exec({6'h02, 1'b0, 7'd3});
    rd(`SXE_ADR_ACCUM, 32'hff, "rsub accum");
    rd(`SXE_ADR_FLAGS, 32'h00, "rsub borrow");
    // Nibble exchange leaves preset flags alone
    bus(1'b1, `SXE_ADR_FLAGS, 32'h05);
    setf(7'd9, 8'ha5);
    exec({6'h0e, 1'b0, 7'd9});
    rd(`SXE_ADR_ACCUM, 32'h5a, "swap accum");
    rd(`SXE_ADR_FLAGS, 32'h05, "swap flags");
    exec({6'h0e, 1'b1, 7'd9});
    rd(`SXE_ADR_FDAT, 32'h5a, "swap file");
    // Register xor: only the zero flag moves
    bus(1'b1, `SXE_ADR_FLAGS, 32'h03);
    setf(7'd12, 8'haf);
    bus(1'b1, `SXE_ADR_ACCUM, 32'hb5);
    exec({6'h06, 1'b1, 7'd12});
    rd(`SXE_ADR_FDAT, 32'h1a, "rxor file");
    rd(`SXE_ADR_FLAGS, 32'h03, "rxor flags");
    bus(1'b1, `SXE_ADR_ACCUM, 32'h1a);
    exec({6'h06, 1'b0, 7'd12});
    rd(`SXE_ADR_ACCUM, 32'h00, "rxor accum");
    rd(`SXE_ADR_FLAGS, 32'h07, "rxor zero");
    // Literal xor, phases watched through the status word
    bus(1'b1, `SXE_ADR_ACCUM, 32'hb5);
    bus(1'b1, `SXE_ADR_INSTR, {18'h0, 6'h3a, 8'haf});
    rd(`SXE_ADR_STAT, 32'h101, "phase mid");
    rd(`SXE_ADR_STAT, 32'h40, "one cycle");
    rd(`SXE_ADR_ACCUM, 32'h1a, "lxor accum");
    rd(`SXE_ADR_FLAGS, 32'h03, "lxor zero");
    // Direction loads for operands 5 to 7, then an operand flagged bad
    bus(1'b1, `SXE_ADR_FLAGS, 32'h02);
    for (int f = 5; f < 8; f++) begin
      bus(1'b1, `SXE_ADR_ACCUM, 32'h11 * (f - 4));
      exec({11'h00c, f[2:0]});
    end
    rd(`SXE_ADR_DIR, 32'h00332211, "dir load");
    rd(`SXE_ADR_FLAGS, 32'h02, "dir flags");
    bus(1'b1, `SXE_ADR_ACCUM, 32'h44);
    exec({11'h00c, 3'd4});
    rd(`SXE_ADR_STAT, 32'h42, "dir bad");
    rd(`SXE_ADR_DIR, 32'h00332211, "dir kept");
    // Unknown opcode is flagged bad and writes nothing
    exec(14'h3fff);
    rd(`SXE_ADR_STAT, 32'h42, "unknown bad");
    rd(`SXE_ADR_ACCUM, 32'h44, "unknown accum");
    // Back-to-back instruction writes: the second is turned away
    bus(1'b1, `SXE_ADR_INSTR, {18'h0, 6'h3a, 8'h01});
    bus(1'b1, `SXE_ADR_INSTR, {18'h0, 6'h3a, 8'h02});
    wait_idle();
    rd(`SXE_ADR_ACCUM, 32'h45, "busy accum");
    rd(`SXE_ADR_STAT, 32'h44, "busy refused");
    conclude();
  end
endmodule : sxe_exec_unit_tb_top
`default_nettype wire

/* File: logic/sxe_exec_unit.sv */
// Subtract, swap, exclusive-OR and direction-load datapath with a Wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "sxe_defs.svh"
module sxe_exec_unit
  import sxe_pkg::*;
(
  input wire logic clk_in, // 50 MHz core clock
  input wire logic rstn_in, // Synchronous reset, active low
  input wire logic wb_cyc_in, // Bus cycle
  input wire logic wb_stb_in, // Strobe
  input wire logic wb_we_in, // Write enable
  input wire logic [7:0] wb_adr_in, // Byte address
  input wire logic [3:0] wb_sel_in, // Byte lanes
  input wire logic [31:0] wb_dat_in, // Write data
  output logic [31:0] wb_dat_out, // Read data
  output logic wb_ack_out // Acknowledge
);
  // Merges write data into an old word under the byte lanes
  function automatic logic [31:0] sxe_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : sxe_merge

  sxe_state_e state_ff, nxt_state; // Phase of the instruction cycle
  sxe_op_e op_ff, nxt_op; // Decoded operation
  logic [13:0] ir_ff, nxt_ir; // Instruction word
  logic [7:0] w_ff, nxt_w; // Accumulator
  logic c_ff, nxt_c; // Carry, no borrow
  logic dc_ff, nxt_dc; // Digit carry
  logic z_ff, nxt_z; // Zero
  logic [7:0] opb_ff, nxt_opb; // Operand read in Q2
  logic [7:0] res_ff, nxt_res; // Result of Q3
  logic fc_ff, nxt_fc; // Carry computed in Q3
  logic fdc_ff, nxt_fdc; // Digit carry computed in Q3
  logic bad_ff, nxt_bad; // Illegal instruction seen
  logic ref_ff, nxt_ref; // Instruction refused while busy
  logic [6:0] fadr_ff, nxt_fadr; // Software file pointer
  logic [7:0] dir_ff [3]; // Direction registers 5..7
  logic [7:0] nxt_dir [3];
  logic [7:0] file_mem [128]; // File registers
  logic mem_we; // File write strobe
  logic [6:0] mem_wa; // File write address
  logic [7:0] mem_wd; // File write data
  logic ack_ff, nxt_ack; // Bus acknowledge
  logic [31:0] rd_ff, nxt_rd; // Bus read data
  logic req; // New bus request
  logic wr; // Bus write takes effect
  logic idle; // No instruction running
  logic [8:0] diff9; // Full subtraction with carry
  logic [4:0] diff5; // Low-nibble subtraction
  logic [31:0] rmux; // Read data selection

  assign req = wb_cyc_in & wb_stb_in & ~ack_ff;
  assign wr = wb_cyc_in & wb_stb_in & wb_we_in & ack_ff;
  assign idle = (state_ff == ST_IDLE);
  assign wb_ack_out = ack_ff;
  assign wb_dat_out = rd_ff;

  // Subtraction of the accumulator from operand b as b plus inverted accumulator plus one
  assign diff9 = {1'b0, opb_ff} + {1'b0, ~w_ff} + 9'h001;
  assign diff5 = {1'b0, opb_ff[3:0]} + {1'b0, ~w_ff[3:0]} + 5'h01;

  // Register read selection; unmapped offsets read zero
  always_comb begin
    rmux = 32'h0;
    unique case (wb_adr_in)
      `SXE_ADR_INSTR: rmux = {18'h0, ir_ff};
      `SXE_ADR_ACCUM: rmux = {24'h0, w_ff};
      `SXE_ADR_FLAGS: rmux = {29'h0, z_ff, dc_ff, c_ff};
      `SXE_ADR_DIR: rmux = {8'h0, dir_ff[2], dir_ff[1], dir_ff[0]};
      `SXE_ADR_FADR: rmux = {25'h0, fadr_ff};
      `SXE_ADR_FDAT: rmux = {24'h0, file_mem[fadr_ff]};
      `SXE_ADR_STAT: rmux = {21'h0, state_ff, 3'h0, ref_ff, bad_ff, ~idle};
      default: rmux = 32'h0;
    endcase
  end

  // Bus slave next state: one wait state, then a single-cycle ack
  always_comb begin
    nxt_ack = req;
    nxt_rd = req ? rmux : rd_ff;
  end

  // Bus slave registers
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ack_ff <= 1'b0;
      rd_ff <= 32'h0;
    end else begin
      ack_ff <= nxt_ack;
      rd_ff <= nxt_rd;
    end
  end

  // Instruction sequencer and software writes
  always_comb begin
    logic [31:0] m;
    m = 32'h0;
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_ir = ir_ff;
    nxt_w = w_ff;
    nxt_c = c_ff;
    nxt_dc = dc_ff;
    nxt_z = z_ff;
    nxt_opb = opb_ff;
    nxt_res = res_ff;
    nxt_fc = fc_ff;
    nxt_fdc = fdc_ff;
    nxt_bad = bad_ff;
    nxt_ref = ref_ff;
    nxt_fadr = fadr_ff;
    nxt_dir = dir_ff;
    mem_we = 1'b0;
    mem_wa = ir_ff[6:0];
    mem_wd = res_ff;
    unique case (state_ff)
      ST_IDLE: begin
        // Software owns the state only between instructions
        if (wr) begin
          unique case (wb_adr_in)
            `SXE_ADR_INSTR: begin
              m = sxe_merge({18'h0, ir_ff}, wb_dat_in, wb_sel_in);
              nxt_ir = m[13:0];
              nxt_bad = 1'b0;
              nxt_ref = 1'b0;
              nxt_state = ST_Q1;
            end
            `SXE_ADR_ACCUM: begin
              m = sxe_merge({24'h0, w_ff}, wb_dat_in, wb_sel_in);
              nxt_w = m[7:0];
            end
            `SXE_ADR_FLAGS: begin
              m = sxe_merge({29'h0, z_ff, dc_ff, c_ff}, wb_dat_in, wb_sel_in);
              nxt_c = m[`SXE_FLAG_C];
              nxt_dc = m[`SXE_FLAG_DC];
              nxt_z = m[`SXE_FLAG_Z];
            end
            `SXE_ADR_FADR: begin
              m = sxe_merge({25'h0, fadr_ff}, wb_dat_in, wb_sel_in);
              nxt_fadr = m[6:0];
            end
            `SXE_ADR_FDAT: begin
              m = sxe_merge({24'h0, file_mem[fadr_ff]}, wb_dat_in, wb_sel_in);
              mem_we = 1'b1;
              mem_wa = fadr_ff;
              mem_wd = m[7:0];
            end
            default: m = 32'h0;
          endcase
        end
      end
      ST_Q1: begin
        // Decode
        nxt_op = sxe_decode(ir_ff);
        nxt_state = ST_Q2;
        if (wr && wb_adr_in == `SXE_ADR_INSTR) nxt_ref = 1'b1;
      end
      ST_Q2: begin
        // Read the literal or the file register
        if (op_ff == OP_LSUB || op_ff == OP_LXOR) nxt_opb = ir_ff[7:0];
        else nxt_opb = file_mem[ir_ff[6:0]];
        nxt_state = ST_Q3;
        if (wr && wb_adr_in == `SXE_ADR_INSTR) nxt_ref = 1'b1;
      end
      ST_Q3: begin
        // Process
        nxt_fc = diff9[8];
        nxt_fdc = diff5[4];
        unique case (op_ff)
          OP_LSUB, OP_RSUB: nxt_res = diff9[7:0];
          OP_SWAP: nxt_res = {opb_ff[3:0], opb_ff[7:4]};
          OP_RXOR, OP_LXOR: nxt_res = opb_ff ^ w_ff;
          OP_DIR: begin
            nxt_res = w_ff;
            if (ir_ff[2:0] < 3'h5) nxt_bad = 1'b1;
          end
          OP_NONE: begin
            nxt_res = 8'h00;
            nxt_bad = 1'b1;
          end
          default: nxt_res = 8'h00;
        endcase
        nxt_state = ST_Q4;
        if (wr && wb_adr_in == `SXE_ADR_INSTR) nxt_ref = 1'b1;
      end
      ST_Q4: begin
        // Write the destination
        unique case (op_ff)
          OP_LSUB, OP_LXOR: nxt_w = res_ff;
          OP_RSUB, OP_SWAP, OP_RXOR: begin
            if (ir_ff[7]) mem_we = 1'b1;
            else nxt_w = res_ff;
          end
          OP_DIR: begin
            if (!bad_ff) nxt_dir[ir_ff[1:0] - 2'h1] = w_ff;
          end
          default: nxt_w = w_ff;
        endcase
        if (op_ff == OP_LSUB || op_ff == OP_RSUB) begin
          nxt_c = fc_ff;
          nxt_dc = fdc_ff;
        end
        if (op_ff == OP_LSUB || op_ff == OP_RSUB || op_ff == OP_RXOR || op_ff == OP_LXOR)
          nxt_z = (res_ff == 8'h00);
        nxt_state = ST_IDLE;
        if (wr && wb_adr_in == `SXE_ADR_INSTR) nxt_ref = 1'b1;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_ff <= ST_IDLE;
      op_ff <= OP_NONE;
      ir_ff <= 14'h0;
      w_ff <= `SXE_RST_BYTE;
      c_ff <= 1'b0;
      dc_ff <= 1'b0;
      z_ff <= 1'b0;
      opb_ff <= `SXE_RST_BYTE;
      res_ff <= `SXE_RST_BYTE;
      fc_ff <= 1'b0;
      fdc_ff <= 1'b0;
      bad_ff <= 1'b0;
      ref_ff <= 1'b0;
      fadr_ff <= 7'h0;
      dir_ff <= '{`SXE_RST_DIR, `SXE_RST_DIR, `SXE_RST_DIR};
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      ir_ff <= nxt_ir;
      w_ff <= nxt_w;
      c_ff <= nxt_c;
      dc_ff <= nxt_dc;
      z_ff <= nxt_z;
      opb_ff <= nxt_opb;
      res_ff <= nxt_res;
      fc_ff <= nxt_fc;
      fdc_ff <= nxt_fdc;
      bad_ff <= nxt_bad;
      ref_ff <= nxt_ref;
      fadr_ff <= nxt_fadr;
      dir_ff <= nxt_dir;
    end
  end

  // File register storage, no reset
  always_ff @(posedge clk_in) begin
    if (mem_we) file_mem[mem_wa] <= mem_wd;
  end

  // Checks
  a_lsub_result: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state_ff == ST_Q3 && op_ff == OP_LSUB) |-> ##2
    (w_ff == 8'($past(opb_ff, 2) - $past(w_ff, 2))))
    else $error("literal subtract result wrong");
  a_carry_pos: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state_ff == ST_Q3 && (op_ff == OP_LSUB || op_ff == OP_RSUB) && opb_ff > w_ff)
    |-> ##2 (c_ff && !z_ff))
    else $error("positive result flags wrong");
  a_zero_sub: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state_ff == ST_Q3 && (op_ff == OP_LSUB || op_ff == OP_RSUB) && opb_ff == w_ff)
    |-> ##2 (c_ff && z_ff))
    else $error("zero result flags wrong");
  a_borrow_neg: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state_ff == ST_Q3 && (op_ff == OP_LSUB || op_ff == OP_RSUB) && opb_ff < w_ff)
    |-> ##2 !c_ff)
    else $error("borrow not flagged");
  a_rsub_dest: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state_ff == ST_Q4 && op_ff == OP_RSUB) |->
    (mem_we == ir_ff[7]) && (w_ff == $past(w_ff)) ##1 (ir_ff[7] || w_ff == $past(res_ff)))
    else $error("register subtract routing wrong");
  a_swap_flags: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state_ff == ST_Q3 && op_ff == OP_SWAP) |=>
    (res_ff == {$past(opb_ff[3:0]), $past(opb_ff[7:4])}) ##1
    ({c_ff, dc_ff, z_ff} == $past({c_ff, dc_ff, z_ff}, 2)))
    else $error("nibble exchange wrong");
  a_dir_load: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state_ff == ST_Q4 && op_ff == OP_DIR && ir_ff[2:0] == 3'h5) |=>
    (dir_ff[0] == $past(w_ff)) && ({c_ff, dc_ff, z_ff} == $past({c_ff, dc_ff, z_ff})))
    else $error("direction load wrong");
  a_xor_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state_ff == ST_Q3 && (op_ff == OP_RXOR || op_ff == OP_LXOR)) |-> ##2
    (z_ff == ($past(opb_ff, 2) == $past(w_ff, 2))) && (c_ff == $past(c_ff, 2)))
    else $error("xor zero flag wrong");
  a_phase_walk: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state_ff == ST_Q1) |=> (state_ff == ST_Q2) ##1 (state_ff == ST_Q3)
    ##1 (state_ff == ST_Q4) ##1 (state_ff == ST_IDLE))
    else $error("phase sequence broken");
  a_dc_borrow: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state_ff == ST_Q3 && (op_ff == OP_LSUB || op_ff == OP_RSUB)) |-> ##2
    (dc_ff == ($past(opb_ff[3:0], 2) >= $past(w_ff[3:0], 2))))
    else $error("digit carry wrong");
endmodule : sxe_exec_unit
`default_nettype wire

/* File: pkg/sxe_defs.svh */
// Register offsets, field positions and reset values of the execution unit
`ifndef SXE_DEFS_SVH
`define SXE_DEFS_SVH
`define SXE_ADR_INSTR 8'h00
`define SXE_ADR_ACCUM 8'h04
`define SXE_ADR_FLAGS 8'h08
`define SXE_ADR_DIR 8'h0c
`define SXE_ADR_FADR 8'h10
`define SXE_ADR_FDAT 8'h14
`define SXE_ADR_STAT 8'h18
`define SXE_FLAG_C 0
`define SXE_FLAG_DC 1
`define SXE_FLAG_Z 2
`define SXE_STAT_BUSY 0
`define SXE_STAT_BAD 1
`define SXE_STAT_REFUSED 2
`define SXE_RST_BYTE 8'h00
`define SXE_RST_DIR 8'hff
`endif

/* File: pkg/sxe_pkg.sv */
// Types and opcode decoding of the execution unit
`default_nettype none
package sxe_pkg;
  // Instruction cycle phases, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_Q1 = 5'h02,
    ST_Q2 = 5'h04,
    ST_Q3 = 5'h08,
    ST_Q4 = 5'h10
  } sxe_state_e;

  // Operation classes
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_LSUB = 3'h1,
    OP_RSUB = 3'h2,
    OP_SWAP = 3'h3,
    OP_RXOR = 3'h4,
    OP_LXOR = 3'h5,
    OP_DIR = 3'h6
  } sxe_op_e;

  // Maps a 14-bit instruction word to its operation class
  function automatic sxe_op_e sxe_decode(input logic [13:0] ir);
    sxe_op_e op;
    op = OP_NONE;
    if (ir[13:9] == 5'h1e) op = OP_LSUB;
    else if (ir[13:8] == 6'h3a) op = OP_LXOR;
    else if (ir[13:8] == 6'h02) op = OP_RSUB;
    else if (ir[13:8] == 6'h0e) op = OP_SWAP;
    else if (ir[13:8] == 6'h06) op = OP_RXOR;
    else if (ir[13:3] == 11'h00c) op = OP_DIR;
    return op;
  endfunction : sxe_decode
endpackage : sxe_pkg
`default_nettype wire
